// file: verilog/leil_regs.svh
// Register offsets, reset values and field positions of the line edge interrupt block
`ifndef LEIL_REGS_SVH
`define LEIL_REGS_SVH
`define LEIL_ENABLE_OFFS     12'h0114
`define LEIL_PENDING_OFFS    12'h0118
`define LEIL_CONTROL_OFFS    12'h011C
`define LEIL_MASK_OFFS       12'h0130
`define LEIL_ENABLE_RESET    32'h0000_0000
`define LEIL_PENDING_RESET   32'h0000_0000
`define LEIL_CONTROL_RESET   32'h0000_0000
`define LEIL_MASK_RESET      32'hFFFF_FFFF
`define LEIL_RISE_LSB        0
`define LEIL_FALL_LSB        16
`define LEIL_GATE_BIT        0
`define LEIL_NUM_LINES       16
`endif

// file: verilog/leil_pkg.sv
// Types of the line edge interrupt block
package leil_pkg;
  typedef logic [15:0] leil_lines_t;
  typedef struct packed {
    leil_lines_t fall;
    leil_lines_t rise;
  } leil_edge_word_t;
  typedef struct packed {
    logic        resp_valid;
    logic [1:0]  resp;
  } leil_wresp_t;
  typedef enum logic [1:0] {LEIL_W_IDLE, LEIL_W_RESP} leil_wstate_t;
endpackage

// file: verilog/leil_top.sv
// Line edge interrupt logic with AXI4-Lite register slave
// Operation
// [RULE_01] Enable bit 16+n arms falling-edge interrupts of line n.
// [RULE_02] Armed line going high to low raises a falling-edge request.
// [RULE_03] Enable bit n arms rising-edge interrupts of line n.
// [RULE_04] Armed line going low to high raises a rising-edge request.
// [RULE_05] Requests reach the interrupt output only while the master gate is set.
// [RULE_06] Pending bits 31..16 show falling-edge requests, line n at 16+n.
// [RULE_07] Pending bits 15..0 show rising-edge requests, line n at n.
// [RULE_08] Writing one to a pending bit clears it; software writes handled bits.
// [RULE_09] Edges are taken from the debounced level, outputs included.
// [RULE_10] Writing zero leaves a bit; a new edge beats a same-cycle clear.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "leil_regs.svh"
module leil_top (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address and data
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Debounced line levels
  input  wire leil_pkg::leil_lines_t debounced_line_state,
  // Interrupt
  output logic                       irq
);
  import leil_pkg::*;

  // Register selection codes of the address decoder
  localparam logic [2:0] sel_none    = 3'd0;
  localparam logic [2:0] sel_enable  = 3'd1;
  localparam logic [2:0] sel_pending = 3'd2;
  localparam logic [2:0] sel_control = 3'd3;
  localparam logic [2:0] sel_mask    = 3'd4;

  function automatic logic [2:0] leil_decode(input logic [11:0] addr);
    case (addr)
      `LEIL_ENABLE_OFFS:  leil_decode = sel_enable;
      `LEIL_PENDING_OFFS: leil_decode = sel_pending;
      `LEIL_CONTROL_OFFS: leil_decode = sel_control;
      `LEIL_MASK_OFFS:    leil_decode = sel_mask;
      default:            leil_decode = sel_none;
    endcase
  endfunction

  // Unmapped offsets answer with a slave error, mapped ones with okay
  function automatic logic [1:0] leil_resp(input logic [2:0] sel);
    leil_resp = (sel == sel_none) ? 2'b10 : 2'b00;
  endfunction

  function automatic logic [31:0] leil_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    leil_merge = res;
  endfunction

  leil_edge_word_t line_edge_irq_enable_reg;
  leil_edge_word_t line_edge_irq_pending_reg;
  leil_edge_word_t line_edge_irq_pending_next;
  leil_edge_word_t irq_mask_reg;
  logic [31:0]     irq_control_reg;
  leil_lines_t     sync1_reg;
  leil_lines_t     sync2_reg;
  leil_lines_t     prev_reg;
  logic            prev_valid_reg;
  leil_lines_t     rise_hit;
  leil_lines_t     fall_hit;
  logic            master_irq_gate;

  // Write channel state
  leil_wstate_t    wstate_reg;
  logic            aw_held_reg;
  logic            w_held_reg;
  logic [11:0]     awaddr_reg;
  logic [31:0]     wdata_reg;
  logic [3:0]      wstrb_reg;
  logic            wr_fire;
  logic [2:0]      wr_sel;
  logic [31:0]     wr_clear;

  // Two-stage synchroniser for the asynchronous line levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= debounced_line_state;
      sync2_reg <= sync1_reg;
    end
  end

  // Edge history: previous settled level and whether it is valid yet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg       <= '0;
      prev_valid_reg <= 1'b0;
    end else begin
      prev_reg       <= sync2_reg;
      prev_valid_reg <= 1'b1;
    end
  end

  // No edge is reported for the first sample after reset
  leil_lines_t rise_seen;
  leil_lines_t fall_seen;
  for (genvar n = 0; n < `LEIL_NUM_LINES; n++) begin : g_edge
    assign rise_seen[n] = prev_valid_reg && !prev_reg[n] && sync2_reg[n]; // RULE_09
    assign fall_seen[n] = prev_valid_reg && prev_reg[n] && !sync2_reg[n]; // RULE_09
    assign rise_hit[n]  = rise_seen[n] && line_edge_irq_enable_reg.rise[n]; // RULE_03 RULE_04
    assign fall_hit[n]  = fall_seen[n] && line_edge_irq_enable_reg.fall[n]; // RULE_01 RULE_02
  end

  // Write handshake: address and data taken in either order
  logic [11:0] wr_addr;
  assign s_axi_awready = (wstate_reg == LEIL_W_IDLE) && !aw_held_reg;
  assign s_axi_wready  = (wstate_reg == LEIL_W_IDLE) && !w_held_reg;
  assign wr_fire = (wstate_reg == LEIL_W_IDLE)
                   && (aw_held_reg || s_axi_awvalid) && (w_held_reg || s_axi_wvalid);
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_sel  = leil_decode(wr_addr);

  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;

  // One strobe per register for the accepted write
  logic wr_en_enable;
  logic wr_en_pending;
  logic wr_en_control;
  logic wr_en_mask;
  assign wr_en_enable  = wr_fire && (wr_sel == sel_enable);
  assign wr_en_pending = wr_fire && (wr_sel == sel_pending);
  assign wr_en_control = wr_fire && (wr_sel == sel_control);
  assign wr_en_mask    = wr_fire && (wr_sel == sel_mask);

  // Write address held while the data half is still missing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 12'h000;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end
  end

  // Write data held while the address half is still missing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end
  end

  // Write channel state: one response outstanding at most
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_reg <= LEIL_W_IDLE;
    end else begin
      case (wstate_reg)
        LEIL_W_IDLE: begin
          if (wr_fire) begin
            wstate_reg <= LEIL_W_RESP;
          end
        end
        LEIL_W_RESP: begin
          if (s_axi_bready) begin
            wstate_reg <= LEIL_W_IDLE;
          end
        end
        default: wstate_reg <= LEIL_W_IDLE;
      endcase
    end
  end

  // Write response stands until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= leil_resp(wr_sel);
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Enable register, falling half above the rising half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_edge_irq_enable_reg <= `LEIL_ENABLE_RESET;
    end else if (wr_en_enable) begin
      line_edge_irq_enable_reg <= leil_merge(line_edge_irq_enable_reg,
                                             wr_data, wr_strb); // RULE_01 RULE_03
    end
  end

  // Control register: only the master gate bit is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_control_reg <= `LEIL_CONTROL_RESET;
    end else if (wr_en_control) begin
      irq_control_reg <= leil_merge(irq_control_reg, wr_data, wr_strb) & 32'h0000_0001;
    end
  end
  assign master_irq_gate = irq_control_reg[`LEIL_GATE_BIT]; // RULE_05

  // Mask register: a one lets the matching pending bit through
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= `LEIL_MASK_RESET;
    end else if (wr_en_mask) begin
      irq_mask_reg <= leil_merge(irq_mask_reg, wr_data, wr_strb);
    end
  end

  // Pending flags: write one clears, a fresh edge wins over the clear
  assign wr_clear = wr_en_pending ? leil_merge(32'h0000_0000, wr_data, wr_strb)
                                  : 32'h0000_0000; // RULE_08
  always_comb begin
    line_edge_irq_pending_next = (line_edge_irq_pending_reg & ~wr_clear)
                                 | {fall_hit, rise_hit}; // RULE_06 RULE_07 RULE_10
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_edge_irq_pending_reg <= `LEIL_PENDING_RESET;
    end else begin
      line_edge_irq_pending_reg <= line_edge_irq_pending_next;
    end
  end

  // Interrupt sources that survive the mask, then the master gate
  logic [31:0] irq_sources;
  logic        irq_next;
  assign irq_sources = line_edge_irq_pending_reg & irq_mask_reg;
  assign irq_next    = master_irq_gate && (|irq_sources); // RULE_05

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next; // RULE_05
    end
  end

  // Read data selection
  logic [2:0]  rd_sel;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;
  assign rd_sel = leil_decode(s_axi_araddr);
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = leil_resp(rd_sel);
    case (rd_sel)
      sel_enable:  rd_word = line_edge_irq_enable_reg;
      sel_pending: rd_word = line_edge_irq_pending_reg; // RULE_06 RULE_07
      sel_control: rd_word = irq_control_reg;
      sel_mask:    rd_word = irq_mask_reg;
      default:     rd_word = 32'h0000_0000;
    endcase
  end

  // Read channel: one read at a time, answer one cycle after address
  logic rd_take;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Read data and response are captured with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (rd_take) begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
    end
  end
endmodule

// file: sim/leil_chk_sva.sv
// Handshake and interrupt checks for the line edge block
`timescale 1ns/1ps
module leil_chk (
  // Watched ports
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_b_new; $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2); endsequence
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read lost");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid lost");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid lost");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read early");
  a_irq_fall: assert property ($fell(irq) && $past(aresetn) |-> s_b_new)
    else $error("irq fell alone");
  a_irq_boot: assert property ($rose(aresetn) |-> !irq [*2])
    else $error("irq after reset");
endmodule
bind leil_top leil_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .irq);

// file: sim/leil_line_model.sv
// Filtered TTL line source feeding the edge detector
`timescale 1ns/1ps
module leil_line_model #(
  parameter int LAG = 3
) (
  // Clock, requested and settled levels
  input wire logic                  aclk,
  input wire leil_pkg::leil_lines_t want,
  output leil_pkg::leil_lines_t     lines = '0
);
  import leil_pkg::*;
  int cnt = 0;
  // A new level shows only after LAG+1 cycles, as behind a slow filter
  always @(posedge aclk) begin
    if (want == lines) cnt <= 0;
    else if (cnt >= LAG) lines <= want;
    else cnt <= cnt + 1;
  end
endmodule

// file: sim/leil_top_bench.sv
// Register-level tests of the line edge block
`timescale 1ns/1ps
module leil_top_bench;
  import leil_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, irq;
  logic        s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  leil_lines_t debounced_line_state, want;
  int          err_count = 0, total_checks = 0;
  always #25 aclk = ~aclk;
  leil_line_model u_lines (.aclk, .want, .lines(debounced_line_state));
  leil_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .debounced_line_state, .irq);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && s_axi_awready) begin
        aw_open = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_open && s_axi_wready) begin
        w_open = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk("bresp", 32'(s_axi_bresp), 32'(r));
  endtask
  task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] e,
                    input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(nm, s_axi_rdata, e);
    chk("rresp", 32'(s_axi_rresp), 32'(r));
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge aclk);
    err_count++;
    print_verdict();
  end
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, want} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h114, "en", 32'h0000_0000, 2'b00);
    rd(12'h118, "pend", 32'h0000_0000, 2'b00);
    rd(12'h130, "mask", 32'hFFFF_FFFF, 2'b00);
    rd(12'h200, "bad", 32'h0000_0000, 2'b10);
    wr(12'h200, 32'hFFFF_FFFF, 2'b10);
    wr(12'h114, 32'h8000_0001);
    want <= 16'h8009;
    repeat (12) @(posedge aclk);
    want <= 16'h0000;
    repeat (12) @(posedge aclk);
    rd(12'h118, "pend", 32'h8000_0001, 2'b00);
    chk("irq", 32'(irq), 32'h0000_0000);
    wr(12'h130, 32'h0000_0000);
    wr(12'h11C, 32'h0000_0001);
    chk("irq", 32'(irq), 32'h0000_0000);
    wr(12'h130, 32'hFFFF_FFFF);
    @(posedge aclk);
    chk("irq", 32'(irq), 32'h0000_0001);
    wr(12'h118, 32'h0000_0001);
    rd(12'h118, "pend", 32'h8000_0000, 2'b00);
    wr(12'h118, 32'h8000_0000);
    @(posedge aclk);
    chk("irq", 32'(irq), 32'h0000_0000);
    print_verdict();
  end
endmodule
